// ---- ulrg_pkg.sv ----
package ulrg_pkg;

    // Transmit command byte layout
    localparam int unsigned CMD_TYPE_MSB = 7;
    localparam int unsigned CMD_TYPE_LSB = 6;
    localparam int unsigned CMD_ADDR_MSB = 5;
    localparam int unsigned PID_MSB      = 3;

    localparam logic [1:0] CT_SPECIAL   = 2'h0;
    localparam logic [1:0] CT_TRANSMIT  = 2'h1;
    localparam logic [1:0] CT_REG_WRITE = 2'h2;
    localparam logic [1:0] CT_REG_READ  = 2'h3;

    localparam logic [5:0] EXT_ADDR_CODE = 6'h2F;
    localparam logic [7:0] IDLE_BYTE     = 8'h00;
    localparam logic [1:0] PID_FIELD_TOP = 2'h0;
    localparam logic [3:0] NOPID_CODE    = 4'h0;

    // Interface clock
    localparam int unsigned MCLK_PERIOD_NS = 40;

    typedef enum logic [12:0] {
        ST_IDLE    = 13'h0001,
        ST_WCMD    = 13'h0002,
        ST_WEXT    = 13'h0004,
        ST_WDATA   = 13'h0008,
        ST_WSTP    = 13'h0010,
        ST_WCOMMIT = 13'h0020,
        ST_RCMD    = 13'h0040,
        ST_REXT    = 13'h0080,
        ST_RTURN   = 13'h0100,
        ST_RDATA   = 13'h0200,
        ST_RBACK   = 13'h0400,
        ST_TX      = 13'h0800,
        ST_IGNORE  = 13'h1000
    } ulrg_state_e;

    function automatic logic [1:0] cmd_type(input logic [7:0] b);
        return b[CMD_TYPE_MSB:CMD_TYPE_LSB];
    endfunction

    function automatic logic cmd_is_ext(input logic [7:0] b);
        return b[CMD_ADDR_MSB:0] == EXT_ADDR_CODE;
    endfunction

endpackage

// ---- ulrg_cmd_decode.sv ----
`timescale 1ns/1ps
module ulrg_cmd_decode
    import ulrg_pkg::*;
(
    // Command byte from the bus
    input  wire logic [7:0] cmd,
    // Decoded kind
    output logic            is_idle,
    output logic            is_tx,
    output logic            is_write,
    output logic            is_read,
    output logic            is_ext,
    output logic            tx_nopid,
    output logic [3:0]      tx_pid,
    output logic [5:0]      addr6
);

    always_comb begin
        is_idle  = (cmd == IDLE_BYTE);
        is_tx    = (cmd_type(cmd) == CT_TRANSMIT) &&
                   (cmd[CMD_ADDR_MSB:PID_MSB+1] == PID_FIELD_TOP);
        is_write = (cmd_type(cmd) == CT_REG_WRITE);
        is_read  = (cmd_type(cmd) == CT_REG_READ);
        is_ext   = cmd_is_ext(cmd);
        tx_pid   = cmd[PID_MSB:0];
        tx_nopid = is_tx && (cmd[PID_MSB:0] == NOPID_CODE);
        addr6    = cmd[CMD_ADDR_MSB:0];
    end

endmodule

// ---- ulrg_top.sv ----
`timescale 1ns/1ps
module ulrg_top
    import ulrg_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       reset_n,
    // Interface bus, data pins split into in, out and active-low enable
    input  wire logic [7:0] ulpi_data_in,
    output logic      [7:0] ulpi_data_out,
    output logic            ulpi_data_oe_n,
    output logic            ulpi_dir,
    output logic            ulpi_nxt,
    input  wire logic       ulpi_stp,
    // Device condition
    input  wire logic       pll_locked,
    input  wire logic       async_mode,
    // Register array port
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_we,
    input  wire logic [7:0] reg_rdata,
    // Transmit path hand-off
    output logic            tx_start,
    output logic            tx_nopid,
    output logic      [3:0] tx_pid,
    input  wire logic       tx_nxt
);

    ////////////////////////////////////////////////////////////////////////////
    // Command decode

    logic       dec_idle;
    logic       dec_tx;
    logic       dec_write;
    logic       dec_read;
    logic       dec_ext;
    logic       dec_nopid;
    logic [3:0] dec_pid;
    logic [5:0] dec_addr6;

    ulrg_cmd_decode u_decode (
        .cmd      (ulpi_data_in),
        .is_idle  (dec_idle),
        .is_tx    (dec_tx),
        .is_write (dec_write),
        .is_read  (dec_read),
        .is_ext   (dec_ext),
        .tx_nopid (dec_nopid),
        .tx_pid   (dec_pid),
        .addr6    (dec_addr6)
    );

    ////////////////////////////////////////////////////////////////////////////
    // State

    ulrg_state_e st_q;
    ulrg_state_e st_d;
    logic        dir_prev_q;
    logic        dir_prev_d;
    logic [7:0]  addr_q;
    logic [7:0]  addr_d;
    logic [7:0]  wdata_q;
    logic [7:0]  wdata_d;
    logic [7:0]  dout_q;
    logic [7:0]  dout_d;
    logic        oe_n_q;
    logic        oe_n_d;
    logic        tx_start_q;
    logic        tx_start_d;
    logic        tx_nopid_q;
    logic        tx_nopid_d;
    logic [3:0]  tx_pid_q;
    logic [3:0]  tx_pid_d;
    logic        ext_q;
    logic        ext_d;
    logic        dir_now;
    logic        dir_next;
    logic        turn_now;
    logic        accept_cmd;

    // Bus belongs to the device during the turnaround and data cycles of a read and whenever the PLL is not locked
    function automatic logic dir_of(input ulrg_state_e s, input logic locked);
        return !locked || (s == ST_RTURN) || (s == ST_RDATA);
    endfunction

    always_comb begin
        dir_now  = dir_of(st_q, pll_locked);
        dir_next = dir_of(st_d, pll_locked);
        // Bus contents are unknown in the cycle after a direction change
        turn_now = (dir_now != dir_prev_q);
        // Commands are only looked at while the Link owns the bus
        accept_cmd = (st_q == ST_IDLE) && !dir_now && !turn_now && !async_mode;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        st_d       = st_q;
        addr_d     = addr_q;
        wdata_d    = wdata_q;
        ext_d      = ext_q;
        tx_start_d = 1'b0;
        tx_nopid_d = tx_nopid_q;
        tx_pid_d   = tx_pid_q;
        case (st_q)
            ST_IDLE: begin
                if (accept_cmd && !dec_idle) begin
                    addr_d = {2'h0, dec_addr6};
                    ext_d  = dec_ext;
                    if (dec_write) begin
                        st_d = ST_WCMD;
                    end else if (dec_read) begin
                        st_d = ST_RCMD;
                    end else if (dec_tx) begin
                        st_d       = ST_TX;
                        tx_start_d = 1'b1;
                        tx_nopid_d = dec_nopid;
                        tx_pid_d   = dec_pid;
                    end else begin
                        // Unknown command: sit it out until the Link stops
                        st_d = ST_IGNORE;
                    end
                end
            end
            ST_WCMD: begin
                if (ulpi_stp) begin
                    st_d = ST_IDLE;
                end else if (ext_q) begin
                    st_d = ST_WEXT;
                end else begin
                    st_d = ST_WDATA;
                end
            end
            ST_WEXT: begin
                addr_d = ulpi_data_in;
                st_d   = ulpi_stp ? ST_IDLE : ST_WDATA;
            end
            ST_WDATA: begin
                wdata_d = ulpi_data_in;
                st_d    = ulpi_stp ? ST_IDLE : ST_WSTP;
            end
            ST_WSTP: begin
                if (ulpi_stp) begin
                    st_d = ST_WCOMMIT;
                end
            end
            ST_WCOMMIT: begin
                // Commit waits for STP low; a held STP delays it
                if (!ulpi_stp) begin
                    st_d = ST_IDLE;
                end
            end
            ST_RCMD: begin
                if (ulpi_stp) begin
                    st_d = ST_IDLE;
                end else if (ext_q) begin
                    st_d = ST_REXT;
                end else begin
                    st_d = ST_RTURN;
                end
            end
            ST_REXT: begin
                addr_d = ulpi_data_in;
                st_d   = ulpi_stp ? ST_IDLE : ST_RTURN;
            end
            ST_RTURN: begin
                st_d = ST_RDATA;
            end
            ST_RDATA: begin
                st_d = ST_RBACK;
            end
            ST_RBACK: begin
                st_d = ST_IDLE;
            end
            ST_TX, ST_IGNORE: begin
                if (ulpi_stp) begin
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
        // Losing the PLL drops any transfer in flight
        if (!pll_locked) begin
            st_d = ST_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output data path

    always_comb begin
        dir_prev_d = dir_now;
        // Drive only once the direction has been high for a full cycle
        oe_n_d     = !(dir_next && dir_now);
        dout_d     = (st_d == ST_RDATA) ? reg_rdata : IDLE_BYTE;
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st_q       <= ST_IDLE;
            dir_prev_q <= 1'b1;
            addr_q     <= 8'h00;
            wdata_q    <= 8'h00;
            ext_q      <= 1'b0;
            dout_q     <= 8'h00;
            oe_n_q     <= 1'b1;
            tx_start_q <= 1'b0;
            tx_nopid_q <= 1'b0;
            tx_pid_q   <= 4'h0;
        end else begin
            st_q       <= st_d;
            dir_prev_q <= dir_prev_d;
            addr_q     <= addr_d;
            wdata_q    <= wdata_d;
            ext_q      <= ext_d;
            dout_q     <= dout_d;
            oe_n_q     <= oe_n_d;
            tx_start_q <= tx_start_d;
            tx_nopid_q <= tx_nopid_d;
            tx_pid_q   <= tx_pid_d;
        end
    end

    always_comb begin
        ulpi_dir       = dir_now;
        ulpi_nxt       = ((st_q == ST_WCMD) || (st_q == ST_WEXT) || (st_q == ST_WDATA) ||
                          (st_q == ST_RCMD) || (st_q == ST_REXT) ||
                          ((st_q == ST_TX) && tx_nxt)) && pll_locked;
        ulpi_data_out  = dout_q;
        // Direction falls at once when the clock returns; the enable must follow
        ulpi_data_oe_n = oe_n_q || !dir_now;
        reg_addr       = addr_q;
        reg_wdata      = wdata_q;
        // Asynchronous modes freeze the array; no write leaks through
        reg_we         = (st_q == ST_WCOMMIT) && !ulpi_stp && !async_mode;
        tx_start       = tx_start_q;
        tx_nopid       = tx_nopid_q;
        tx_pid         = tx_pid_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    a_write_dir_low: assert property (
        (st_q inside {ST_WCMD, ST_WEXT, ST_WDATA, ST_WSTP, ST_WCOMMIT}) |-> !ulpi_dir)
        else $error("direction high during register write");

    a_write_nxt_seq: assert property (
        (accept_cmd && dec_write && !dec_ext) ##1 (!ulpi_stp && pll_locked)
        |-> ulpi_nxt ##1 (ulpi_nxt && st_q == ST_WDATA) ##1 !ulpi_nxt)
        else $error("immediate write NXT timing wrong");

    a_commit_after_stp: assert property (
        reg_we |-> $past(ulpi_stp) && !ulpi_stp && reg_wdata == $past(ulpi_data_in, 2))
        else $error("write committed without STP release");

    a_write_data_hold: assert property (
        (st_q == ST_WDATA && !ulpi_stp) |=> (reg_wdata == $past(ulpi_data_in)) && !ulpi_nxt)
        else $error("write data not accepted");

    a_ext_addr_take: assert property (
        (st_q == ST_WEXT || st_q == ST_REXT) && !ulpi_stp |=> reg_addr == $past(ulpi_data_in))
        else $error("extended address not captured");

    a_read_turn: assert property (
        (st_q == ST_RCMD && !ext_q && !ulpi_stp && pll_locked)
        |=> ulpi_dir && !ulpi_nxt && ulpi_data_oe_n)
        else $error("read turnaround wrong");

    a_read_data_out: assert property (
        (st_q == ST_RTURN && pll_locked)
        |=> !ulpi_data_oe_n && ulpi_data_out == $past(reg_rdata))
        else $error("read data not driven after turnaround");

    a_read_release: assert property (
        (st_q == ST_RDATA && pll_locked) |=> !ulpi_dir && ulpi_data_oe_n)
        else $error("direction not returned after read data");

    a_ext_read_seq: assert property (
        (st_q == ST_REXT && !ulpi_stp && pll_locked)
        |=> (ulpi_dir && !ulpi_nxt) ##1 (ulpi_dir && !ulpi_data_oe_n) ##1 !ulpi_dir)
        else $error("extended read sequence wrong");

    a_turn_no_drive: assert property (
        (ulpi_dir != $past(ulpi_dir)) |-> ulpi_data_oe_n)
        else $error("bus driven in turnaround cycle");

    a_pll_dir_high: assert property (
        !pll_locked |-> ulpi_dir && !ulpi_nxt)
        else $error("direction low without PLL");

    a_async_freeze: assert property (
        async_mode |-> !reg_we)
        else $error("register write in asynchronous mode");

    a_idle_stays: assert property (
        (accept_cmd && dec_idle) |=> st_q == ST_IDLE)
        else $error("idle byte started a transfer");

    a_tx_start: assert property (
        (accept_cmd && dec_tx) |=> tx_start && tx_pid == $past(dec_pid) ##1 !tx_start)
        else $error("transmit command not handed over");

    c_write: cover property (reg_we && !ext_q);
    c_ext_write: cover property (reg_we && ext_q);
    c_read: cover property (st_q == ST_RDATA && !ext_q);
    c_ext_read: cover property (st_q == ST_RDATA && ext_q);

endmodule

// ---- ulrg_link_model.sv ----
`timescale 1ns/1ps
module ulrg_link_model (
    // Clock
    input  wire logic       mclk,
    // Device side of the bus
    input  wire logic       ulpi_dir,
    input  wire logic       ulpi_nxt,
    input  wire logic [7:0] ulpi_data_out,
    input  wire logic       ulpi_data_oe_n,
    // Resolved bus and stop
    output logic      [7:0] ulpi_data_in,
    output logic            ulpi_stp
);
    logic [7:0] link_data;
    logic       link_oe;
    logic [7:0] bus_last;
    logic       dir_last;

    initial begin
        link_data = 8'h00;
        link_oe   = 1'h1;
        ulpi_stp  = 1'h0;
        bus_last  = 8'h00;
        dir_last  = 1'h0;
    end

    // Released bus toggles every cycle so a stale byte can never look valid
    assign ulpi_data_in = !ulpi_data_oe_n ? ulpi_data_out :
                          (link_oe && !ulpi_dir && !dir_last) ? link_data : ~bus_last;

    always @(posedge mclk) begin
        bus_last <= ulpi_data_in;
        dir_last <= ulpi_dir;
    end

    // Holds a byte until an edge samples nxt high or 20 edges have passed
    task automatic put(input logic [7:0] b, output bit ok);
        int n;
        ok = 1'h0;
        link_data = b;
        for (n = 0; n < 20 && !ok; n++) begin
            @(posedge mclk);
            ok = ulpi_nxt;
        end
        #1;
    endtask

    task automatic xfer(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
                        input int n, input bit rd, output logic [7:0] q);
        bit ok;
        int i;
        q = 8'h00;
        for (i = 0; i < 50 && ulpi_dir; i++) begin
            @(posedge mclk);
            #1;
        end
        put(b0, ok);
        if (ok && n > 1) put(b1, ok);
        if (ok && n > 2) put(b2, ok);
        link_data = 8'h00;
        if (!rd || !ok) begin
            ulpi_stp = 1'h1;
            @(posedge mclk);
            #1;
            ulpi_stp = 1'h0;
        end else begin
            link_oe = 1'h0;
            for (i = 0; i < 20 && !ulpi_dir; i++) @(posedge mclk);
            // Turnaround cycle first; the data cycle ends at the second edge
            repeat (2) @(posedge mclk);
            q = ulpi_data_in;
            for (i = 0; i < 20 && ulpi_dir; i++) @(posedge mclk);
            #1;
            link_oe = 1'h1;
        end
    endtask
endmodule

// ---- test_ulpi_register_access.sv ----
`timescale 1ns/1ps
module test_ulpi_register_access
    import ulrg_pkg::*;
;
    logic       mclk = 1'h0;
    logic       reset_n = 1'h0;
    logic [7:0] ulpi_data_in, ulpi_data_out, reg_addr, reg_wdata, reg_rdata, q;
    logic [7:0] we_addr, we_data;
    logic [4:0] tx_seen;
    logic       ulpi_data_oe_n, ulpi_dir, ulpi_nxt, ulpi_stp, reg_we, tx_start;
    logic       tx_nopid, pll_locked, async_mode, tx_nxt, dir_q, pll_q, dir_hi;
    logic [3:0] tx_pid;
    logic [7:0] regs [256];
    int         failures, samples_checked, cycles, we_cnt, tx_cnt;

    always #(MCLK_PERIOD_NS / 2) mclk = ~mclk;

    ulrg_top dut_u (.mclk(mclk), .reset_n(reset_n), .ulpi_data_in(ulpi_data_in),
        .ulpi_data_out(ulpi_data_out), .ulpi_data_oe_n(ulpi_data_oe_n), .ulpi_dir(ulpi_dir),
        .ulpi_nxt(ulpi_nxt), .ulpi_stp(ulpi_stp), .pll_locked(pll_locked),
        .async_mode(async_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .reg_rdata(reg_rdata), .tx_start(tx_start), .tx_nopid(tx_nopid), .tx_pid(tx_pid),
        .tx_nxt(tx_nxt));

    ulrg_link_model link_u (.mclk(mclk), .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt),
        .ulpi_data_out(ulpi_data_out), .ulpi_data_oe_n(ulpi_data_oe_n),
        .ulpi_data_in(ulpi_data_in), .ulpi_stp(ulpi_stp));

    assign reg_rdata = regs[reg_addr];

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge mclk) begin
        cycles++;
        if (reset_n && pll_locked && pll_q) begin
            if (ulpi_dir !== 1'h1 || dir_q !== 1'h1) check("bus enable", ulpi_data_oe_n, 1'h1);
            if (ulpi_dir === 1'h1) dir_hi = 1'h1;
            if (ulpi_dir === 1'h1) check("nxt with dir", ulpi_nxt, 1'h0);
            if (reg_we === 1'h1) begin
                we_cnt++;
                we_addr = reg_addr;
                we_data = reg_wdata;
                regs[reg_addr] <= reg_wdata;
                check("stp at commit", ulpi_stp, 1'h0);
            end
            if (tx_start === 1'h1) begin
                tx_cnt++;
                tx_seen = {tx_nopid, tx_pid};
                check("tx nxt", ulpi_nxt, tx_nxt);
            end
        end
        dir_q = ulpi_dir;
        pll_q = pll_locked;
        if (cycles == 3000) begin
            failures++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Write then read back the same place; extended when the field is 2Fh
    task automatic t_wr_rd(input logic [7:0] wc, input logic [7:0] ea, input logic [7:0] a,
                           input logic [7:0] d);
        int n0;
        bit ext;
        n0 = we_cnt;
        dir_hi = 1'h0;
        ext = (wc[5:0] == 6'h2F);
        if (ext) link_u.xfer(wc, ea, d, 3, 1'h0, q);
        else link_u.xfer(wc, d, 8'h00, 2, 1'h0, q);
        repeat (2) @(posedge mclk);
        #1;
        check("write strobes", 8'(we_cnt - n0), 8'h01);
        check("write address", we_addr, a);
        check("write data", we_data, d);
        check("dir in write", dir_hi, 1'h0);
        if (ext) link_u.xfer({2'h3, wc[5:0]}, ea, 8'h00, 2, 1'h1, q);
        else link_u.xfer({2'h3, wc[5:0]}, 8'h00, 8'h00, 1, 1'h1, q);
        check("read data", q, d);
        $display("Write and read at %h done", a);
    endtask

    task automatic t_tx(input logic [7:0] c, input logic [4:0] exp);
        int n0;
        n0 = tx_cnt;
        link_u.xfer(c, 8'h3C, 8'h00, 2, 1'h0, q);
        repeat (2) @(posedge mclk);
        #1;
        check("tx starts", 8'(tx_cnt - n0), 8'h01);
        check("tx pid", 8'(tx_seen), 8'(exp));
        $display("Transmit %h done", c);
    endtask

    task automatic t_async;
        int n0;
        n0 = we_cnt;
        async_mode = 1'h1;
        link_u.xfer(8'h85, 8'h11, 8'h00, 2, 1'h0, q);
        repeat (2) @(posedge mclk);
        #1;
        async_mode = 1'h0;
        check("async writes", 8'(we_cnt - n0), 8'h00);
        link_u.xfer(8'hC5, 8'h00, 8'h00, 1, 1'h1, q);
        check("kept value", q, 8'hA5);
        $display("Async hold done");
    endtask

    task automatic t_pll;
        pll_locked = 1'h0;
        @(posedge mclk);
        #1;
        check("dir pll low", ulpi_dir, 1'h1);
        check("nxt pll low", ulpi_nxt, 1'h0);
        repeat (3) @(posedge mclk);
        #1;
        pll_locked = 1'h1;
        repeat (3) @(posedge mclk);
        #1;
        link_u.xfer(8'hC5, 8'h00, 8'h00, 1, 1'h1, q);
        check("read after lock", q, 8'hA5);
        $display("Clock loss done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pll_locked = 1'h1;
        pll_q = 1'h1;
        async_mode = 1'h0;
        tx_nxt = 1'h1;
        foreach (regs[i]) regs[i] = 8'h00;
        repeat (8) @(posedge mclk);
        #1;
        reset_n = 1'h1;
        @(posedge mclk);
        #1;
        check("dir after reset", ulpi_dir, 1'h0);
        check("nxt after reset", ulpi_nxt, 1'h0);
        check("enable after reset", ulpi_data_oe_n, 1'h1);
        @(posedge mclk);
        #1;
        t_wr_rd(8'h80, 8'h00, 8'h00, 8'h5A);
        t_wr_rd(8'h85, 8'h00, 8'h05, 8'hA5);
        t_wr_rd(8'hBF, 8'h00, 8'h3F, 8'hC3);
        t_wr_rd(8'hAE, 8'h00, 8'h2E, 8'h81);
        t_wr_rd(8'hAF, 8'hC3, 8'hC3, 8'h3C);
        t_wr_rd(8'hAF, 8'h2F, 8'h2F, 8'h96);
        t_tx(8'h40, 5'h10);
        t_tx(8'h4A, 5'h0A);
        t_tx(8'h4F, 5'h0F);
        t_async();
        t_pll();
        test_done();
    end
endmodule
